// File: inc/ssrx_pkg.sv
// constants for the serial receive clocking block
package ssrx_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_COMMAND     = 8'h00;
	localparam logic [7:0] OFF_RATE_SCALER = 8'h04;
	localparam logic [7:0] OFF_RX_CLOCK    = 8'h10;
	localparam logic [7:0] OFF_RX_FRAME    = 8'h14;
	localparam logic [7:0] OFF_TX_CLOCK    = 8'h18;
	localparam logic [7:0] OFF_TX_FRAME    = 8'h1C;
	localparam logic [7:0] OFF_RX_WORD     = 8'h20;
	localparam logic [7:0] OFF_TX_WORD     = 8'h24;
	localparam logic [7:0] OFF_RX_SYNC     = 8'h30;
	localparam logic [7:0] OFF_TX_SYNC     = 8'h34;
	localparam logic [7:0] OFF_EVENT_FLAGS = 8'h40;
	localparam logic [7:0] OFF_IRQ_SET     = 8'h44;
	localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h48;
	localparam logic [7:0] OFF_IRQ_STATE   = 8'h4C;
	localparam logic [7:0] OFF_RUN_STATE   = 8'h50;
	// command bit positions
	localparam int CMD_RX_EN   = 0;
	localparam int CMD_RX_DIS  = 1;
	localparam int CMD_TX_EN   = 8;
	localparam int CMD_TX_DIS  = 9;
	localparam int CMD_SOFT_RST = 15;
	// receive clock config field positions
	localparam int RCC_SRC_LSB    = 0;
	localparam int RCC_DRV_LSB    = 2;
	localparam int RCC_INV_BIT    = 5;
	localparam int RCC_START_LSB  = 8;
	localparam int RCC_DELAY_LSB  = 16;
	localparam int RCC_PERIOD_LSB = 24;
	localparam int SCALER_W       = 12;
	// reset values
	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
	localparam logic [31:0] RST_EVENTS = 32'h0000_00CC;
	// clock source and drive codes
	localparam logic [1:0] SRC_DIVIDED = 2'h0;
	localparam logic [1:0] SRC_TX_CLK  = 2'h1;
	localparam logic [1:0] SRC_RX_PIN  = 2'h2;
	localparam logic [2:0] DRV_NONE    = 3'h0;
	localparam logic [2:0] DRV_CONT    = 3'h1;
	// start selection codes
	localparam logic [3:0] ST_CONT = 4'h0;
	localparam logic [3:0] ST_TX   = 4'h1;
	localparam logic [3:0] ST_LOW  = 4'h2;
	localparam logic [3:0] ST_HIGH = 4'h3;
	localparam logic [3:0] ST_FALL = 4'h4;
	localparam logic [3:0] ST_RISE = 4'h5;
	localparam logic [3:0] ST_LVL  = 4'h6;
	localparam logic [3:0] ST_EDGE = 4'h7;
	// receive sequencing states
	typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_DELAY, RX_DATA} ssrx_state_t;
endpackage : ssrx_pkg

// File: logic/ssrx_top.sv
// serial controller register front end with receive clocking
// How it works
// - rx enable command bit enables reception unless disable bit also set
// - tx enable command bit enables transmit; disable bit in same write wins
// - soft reset command resets controller, overriding all other command bits
// - enable and disable commands touch data handling only, clocks keep running
// - scaler zero stops divider; nonzero N gives master clock over 2N
// - divided clock ranges from master/2 down to master/8190
// - clock source: divided, transmit clock, or receive clock pin
// - drive mode 1 drives receive clock on pin unless the source is that pin, 0 leaves pin input
// - invert bit 0 samples on falling edge, 1 on rising edge
// - invert bit affects internal receive clock only, not the pin
// - start mode 0 starts on enable and runs word after word
// - mode 1 follows transmit start; 2 and 3 detect low or high frame level
// - modes 4 and 5 detect falling or rising frame pin edge
// - mode 6 any level change, mode 7 any edge
// - nonzero delay inserts that many receive clock cycles before data
// - delay also applies when following the transmit start
// - period P nonzero gives frame sync every 2(P+1) receive clocks
// - set-mask and clear-mask writes update the interrupt mask
//
// Implementation choice: the APB interface to the registers.
module ssrx_top (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_clock_pin_in,
	output logic             rx_clock_pin_out,
	output logic             rx_clock_pin_oe_n,
	input  wire logic        tx_clock_pin_in,
	input  wire logic        rx_frame_pin_in,
	input  wire logic        tx_start_evt,
	output logic             rx_frame_sync,
	output logic             rx_bit_strobe,
	output logic             rx_data_active,
	output logic             irq
);
	logic        wr_en;
	logic        soft_rst;
	logic        rx_en_q;
	logic        tx_en_q;
	logic [31:0] scaler_q;
	logic [31:0] rx_clk_cfg_q;
	logic [31:0] rx_frm_cfg_q;
	logic [31:0] tx_clk_cfg_q;
	logic [31:0] tx_frm_cfg_q;
	logic [31:0] tx_sync_q;
	logic [31:0] imask_q;
	logic [31:0] rdata_d;
	logic [11:0] div_cnt_q;
	logic        div_clk_q;
	logic [1:0]  rc_sync_q;
	logic [1:0]  tc_sync_q;
	logic [1:0]  fr_sync_q;
	logic        rx_clk_lvl;
	logic        rx_clk_prev_q;
	logic        rx_edge;
	logic [1:0]  clk_src;
	logic [2:0]  clk_drv;
	logic        edge_inv;
	logic [3:0]  start_sel;
	logic [7:0]  delay_cfg;
	logic [7:0]  period_cfg;
	logic        fr_now;
	logic        fr_prev_q;
	logic        start_evt;
	logic [7:0]  dly_cnt_q;
	logic [8:0]  per_cnt_q;
	logic        fsync_q;
	logic        strobe_q;
	ssrx_pkg::ssrx_state_t state_q;

	assign clk_src    = rx_clk_cfg_q[ssrx_pkg::RCC_SRC_LSB +: 2];
	assign clk_drv    = rx_clk_cfg_q[ssrx_pkg::RCC_DRV_LSB +: 3];
	assign edge_inv   = rx_clk_cfg_q[ssrx_pkg::RCC_INV_BIT];
	assign start_sel  = rx_clk_cfg_q[ssrx_pkg::RCC_START_LSB +: 4];
	assign delay_cfg  = rx_clk_cfg_q[ssrx_pkg::RCC_DELAY_LSB +: 8];
	assign period_cfg = rx_clk_cfg_q[ssrx_pkg::RCC_PERIOD_LSB +: 8];

	// apb handshake, zero wait states
	assign wr_en    = psel && penable && pwrite;
	assign pready   = 1'b1;
	assign pslverr  = 1'b0;
	assign soft_rst = wr_en && (paddr == ssrx_pkg::OFF_COMMAND) && pwdata[ssrx_pkg::CMD_SOFT_RST];

	// receive and transmit data enables
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_en_q <= 1'b0;
			tx_en_q <= 1'b0;
		end else if (soft_rst) begin
			rx_en_q <= 1'b0;
			tx_en_q <= 1'b0;
		end else if (wr_en && paddr == ssrx_pkg::OFF_COMMAND) begin
			if (pwdata[ssrx_pkg::CMD_RX_DIS]) begin
				rx_en_q <= 1'b0;
			end else if (pwdata[ssrx_pkg::CMD_RX_EN]) begin
				rx_en_q <= 1'b1;
			end
			if (pwdata[ssrx_pkg::CMD_TX_DIS]) begin
				tx_en_q <= 1'b0;
			end else if (pwdata[ssrx_pkg::CMD_TX_EN]) begin
				tx_en_q <= 1'b1;
			end
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scaler_q     <= ssrx_pkg::RST_ZERO;
			rx_clk_cfg_q <= ssrx_pkg::RST_ZERO;
			rx_frm_cfg_q <= ssrx_pkg::RST_ZERO;
			tx_clk_cfg_q <= ssrx_pkg::RST_ZERO;
			tx_frm_cfg_q <= ssrx_pkg::RST_ZERO;
			tx_sync_q    <= ssrx_pkg::RST_ZERO;
		end else if (soft_rst) begin
			scaler_q     <= ssrx_pkg::RST_ZERO;
			rx_clk_cfg_q <= ssrx_pkg::RST_ZERO;
			rx_frm_cfg_q <= ssrx_pkg::RST_ZERO;
			tx_clk_cfg_q <= ssrx_pkg::RST_ZERO;
			tx_frm_cfg_q <= ssrx_pkg::RST_ZERO;
			tx_sync_q    <= ssrx_pkg::RST_ZERO;
		end else if (wr_en) begin
			case (paddr)
				ssrx_pkg::OFF_RATE_SCALER: scaler_q <= {20'h00000, pwdata[11:0]};
				ssrx_pkg::OFF_RX_CLOCK:    rx_clk_cfg_q <= pwdata & 32'hFFFF_0F3F;
				ssrx_pkg::OFF_RX_FRAME:    rx_frm_cfg_q <= pwdata & 32'h017F_0FBF;
				ssrx_pkg::OFF_TX_CLOCK:    tx_clk_cfg_q <= pwdata & 32'hFFFF_0F3F;
				ssrx_pkg::OFF_TX_FRAME:    tx_frm_cfg_q <= pwdata;
				ssrx_pkg::OFF_TX_SYNC:     tx_sync_q <= pwdata;
				default: ;
			endcase
		end
	end

	// interrupt mask set and clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			imask_q <= ssrx_pkg::RST_ZERO;
		end else if (soft_rst) begin
			imask_q <= ssrx_pkg::RST_ZERO;
		end else if (wr_en && paddr == ssrx_pkg::OFF_IRQ_SET) begin
			imask_q <= imask_q | pwdata;
		end else if (wr_en && paddr == ssrx_pkg::OFF_IRQ_CLEAR) begin
			imask_q <= imask_q & ~pwdata;
		end
	end
	assign irq = |(imask_q & ssrx_pkg::RST_EVENTS);

	// read mux
	always_comb begin
		case (paddr)
			ssrx_pkg::OFF_RATE_SCALER: rdata_d = scaler_q;
			ssrx_pkg::OFF_RX_CLOCK:    rdata_d = rx_clk_cfg_q;
			ssrx_pkg::OFF_RX_FRAME:    rdata_d = rx_frm_cfg_q;
			ssrx_pkg::OFF_TX_CLOCK:    rdata_d = tx_clk_cfg_q;
			ssrx_pkg::OFF_TX_FRAME:    rdata_d = tx_frm_cfg_q;
			ssrx_pkg::OFF_TX_SYNC:     rdata_d = tx_sync_q;
			ssrx_pkg::OFF_EVENT_FLAGS: rdata_d = ssrx_pkg::RST_EVENTS;
			ssrx_pkg::OFF_IRQ_STATE:   rdata_d = imask_q;
			ssrx_pkg::OFF_RUN_STATE:   rdata_d = {30'h0, tx_en_q, rx_en_q};
			default:                   rdata_d = ssrx_pkg::RST_ZERO;
		endcase
	end
	assign prdata = rdata_d;

	// divided clock: toggle every N master clocks, period 2N
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt_q <= 12'h000;
			div_clk_q <= 1'b0;
		end else if (scaler_q[11:0] == 12'h000) begin
			div_cnt_q <= 12'h000;
			div_clk_q <= 1'b0;
		end else if (div_cnt_q >= scaler_q[11:0] - 12'h001) begin
			div_cnt_q <= 12'h000;
			div_clk_q <= ~div_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 12'h001;
		end
	end

	// pin synchronisers, two flops each, only the second is read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rc_sync_q <= 2'h0;
			tc_sync_q <= 2'h0;
			fr_sync_q <= 2'h0;
		end else begin
			rc_sync_q <= {rc_sync_q[0], rx_clock_pin_in};
			tc_sync_q <= {tc_sync_q[0], tx_clock_pin_in};
			fr_sync_q <= {fr_sync_q[0], rx_frame_pin_in};
		end
	end

	// clock source select and sampling edge
	always_comb begin
		case (clk_src)
			ssrx_pkg::SRC_DIVIDED: rx_clk_lvl = div_clk_q;
			ssrx_pkg::SRC_TX_CLK:  rx_clk_lvl = tc_sync_q[1];
			ssrx_pkg::SRC_RX_PIN:  rx_clk_lvl = rc_sync_q[1];
			default:               rx_clk_lvl = 1'b0;
		endcase
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_clk_prev_q <= 1'b0;
		end else begin
			rx_clk_prev_q <= rx_clk_lvl;
		end
	end
	assign rx_edge = edge_inv ? (rx_clk_lvl && !rx_clk_prev_q) : (!rx_clk_lvl && rx_clk_prev_q);

	// clock pin drive: the selected receive clock, taken before the invert bit
	assign rx_clock_pin_out  = (clk_drv == ssrx_pkg::DRV_CONT) ? rx_clk_lvl : 1'b0;
	assign rx_clock_pin_oe_n = !(clk_drv == ssrx_pkg::DRV_CONT && clk_src != ssrx_pkg::SRC_RX_PIN);

	// frame pin history sampled on receive edge
	assign fr_now = fr_sync_q[1];
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fr_prev_q <= 1'b0;
		end else if (rx_edge) begin
			fr_prev_q <= fr_now;
		end
	end

	// start event decode
	always_comb begin
		case (start_sel)
			ssrx_pkg::ST_CONT: start_evt = 1'b1;
			ssrx_pkg::ST_TX:   start_evt = tx_start_evt;
			ssrx_pkg::ST_LOW:  start_evt = !fr_now;
			ssrx_pkg::ST_HIGH: start_evt = fr_now;
			ssrx_pkg::ST_FALL: start_evt = fr_prev_q && !fr_now;
			ssrx_pkg::ST_RISE: start_evt = !fr_prev_q && fr_now;
			ssrx_pkg::ST_LVL:  start_evt = fr_prev_q != fr_now;
			ssrx_pkg::ST_EDGE: start_evt = fr_prev_q != fr_now;
			default:           start_evt = 1'b0;
		endcase
	end

	// receive sequencing: wait for start, delay, then data words
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q   <= ssrx_pkg::RX_IDLE;
			dly_cnt_q <= 8'h00;
		end else if (soft_rst || !rx_en_q) begin
			state_q   <= ssrx_pkg::RX_IDLE;
			dly_cnt_q <= 8'h00;
		end else if (rx_edge) begin
			case (state_q)
				ssrx_pkg::RX_IDLE: state_q <= ssrx_pkg::RX_WAIT;
				ssrx_pkg::RX_WAIT: begin
					if (start_evt && delay_cfg != 8'h00) begin
						state_q   <= ssrx_pkg::RX_DELAY;
						dly_cnt_q <= delay_cfg - 8'h01;
					end else if (start_evt) begin
						state_q <= ssrx_pkg::RX_DATA;
					end
				end
				ssrx_pkg::RX_DELAY: begin
					if (dly_cnt_q == 8'h00) begin
						state_q <= ssrx_pkg::RX_DATA;
					end else begin
						dly_cnt_q <= dly_cnt_q - 8'h01;
					end
				end
				ssrx_pkg::RX_DATA: begin
					if (start_sel != ssrx_pkg::ST_CONT) begin
						state_q <= ssrx_pkg::RX_WAIT;
					end
				end
				default: state_q <= ssrx_pkg::RX_IDLE;
			endcase
		end
	end
	assign rx_data_active = (state_q == ssrx_pkg::RX_DATA);

	// periodic frame sync, independent of enables
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			per_cnt_q <= 9'h000;
			fsync_q   <= 1'b0;
		end else if (soft_rst || period_cfg == 8'h00) begin
			per_cnt_q <= 9'h000;
			fsync_q   <= 1'b0;
		end else if (rx_edge) begin
			if (per_cnt_q >= {period_cfg, 1'b1}) begin
				per_cnt_q <= 9'h000;
				fsync_q   <= 1'b1;
			end else begin
				per_cnt_q <= per_cnt_q + 9'h001;
				fsync_q   <= 1'b0;
			end
		end else begin
			fsync_q <= 1'b0;
		end
	end
	assign rx_frame_sync = fsync_q;

	// sampling strobe out of a flop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= rx_edge && rx_en_q;
		end
	end
	assign rx_bit_strobe = strobe_q;

	// checks
	a_soft_reset_wins: assert property (@(posedge ref_clk) disable iff (rst)
		soft_rst |=> !rx_en_q && !tx_en_q && rx_clk_cfg_q == 32'h0)
		else $error("soft reset did not clear state");
	a_rx_dis_wins: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && paddr == 8'h00 && pwdata[1] |=> !rx_en_q)
		else $error("rx disable lost");
	a_tx_en_sets: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && paddr == 8'h00 && pwdata[8] && !pwdata[9] && !pwdata[15] |=> tx_en_q)
		else $error("tx enable lost");
	a_div_idle: assert property (@(posedge ref_clk) disable iff (rst)
		scaler_q[11:0] == 12'h000 |=> !div_clk_q)
		else $error("divider ran at zero");
	a_div_half: assert property (@(posedge ref_clk) disable iff (rst)
		scaler_q[11:0] == 12'h001 && $past(scaler_q[11:0]) == 12'h001 |=> div_clk_q != $past(div_clk_q))
		else $error("divide by two broken");
	a_pin_not_inverted: assert property (@(posedge ref_clk) disable iff (rst)
		clk_drv == ssrx_pkg::DRV_CONT && clk_src == ssrx_pkg::SRC_DIVIDED |-> rx_clock_pin_out == div_clk_q)
		else $error("pin clock altered");
	a_delay_counts: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == ssrx_pkg::RX_WAIT && rx_edge && start_evt && delay_cfg != 8'h00 && rx_en_q && !soft_rst
		|=> state_q == ssrx_pkg::RX_DELAY)
		else $error("start delay skipped");
	a_no_period: assert property (@(posedge ref_clk) disable iff (rst)
		period_cfg == 8'h00 |=> !fsync_q)
		else $error("frame sync with zero period");
	a_mask_set: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && paddr == 8'h44 && !soft_rst |=> (imask_q & $past(pwdata)) == $past(pwdata))
		else $error("mask set lost");
	a_mask_clear: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && paddr == ssrx_pkg::OFF_IRQ_CLEAR && !soft_rst |=> (imask_q & $past(pwdata)) == 32'h0000_0000)
		else $error("mask clear lost");

	// start delay steps and continuous start, the delay exit built from named sequences
	sequence s_delay_done;
		state_q == ssrx_pkg::RX_DELAY && dly_cnt_q == 8'h00 && rx_edge && rx_en_q && !soft_rst;
	endsequence
	sequence s_data_next;
		state_q == ssrx_pkg::RX_DATA;
	endsequence
	a_delay_exit: assert property (@(posedge ref_clk) disable iff (rst)
		s_delay_done |=> s_data_next)
		else $error("start delay never ended");
	a_delay_step: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == ssrx_pkg::RX_DELAY && dly_cnt_q != 8'h00 && rx_edge && rx_en_q && !soft_rst
		|=> state_q == ssrx_pkg::RX_DELAY && dly_cnt_q == $past(dly_cnt_q) - 8'h01)
		else $error("start delay miscounted");
	a_cont_start: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == ssrx_pkg::RX_WAIT && start_sel == ssrx_pkg::ST_CONT && delay_cfg == 8'h00
		&& rx_edge && rx_en_q && !soft_rst |=> state_q == ssrx_pkg::RX_DATA)
		else $error("continuous start missed");

	// pin, pulse and strobe checks
	a_pin_release: assert property (@(posedge ref_clk) disable iff (rst)
		clk_drv != ssrx_pkg::DRV_CONT |-> rx_clock_pin_oe_n)
		else $error("receive clock pin driven while input");
	a_frame_single: assert property (@(posedge ref_clk) disable iff (rst)
		fsync_q |=> !fsync_q)
		else $error("frame sync pulse too long");
	a_strobe_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!rx_en_q |=> !strobe_q)
		else $error("strobe while receiver off");
endmodule : ssrx_top

// File: tb/ssrx_peer.sv
// serial codec model that drives the receive clock, transmit clock and frame pins
module ssrx_peer (
	input  wire logic ref_clk,
	input  wire logic rx_clk_oe_n,
	input  wire logic rx_clk_out,
	input  wire logic frame_lvl,
	output logic      rx_clock_pin_in,
	output logic      tx_clock_pin_in,
	output logic      rx_frame_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt_q = 6'h00;
	// codec bit clocks run free: 16 cycles on the rx pin, 32 on the tx pin
	always @(posedge ref_clk) cnt_q <= cnt_q + 6'h01;
	// shared rx clock wire: the block wins whenever its enable is low
	assign rx_clock_pin_in = rx_clk_oe_n ? cnt_q[3] : rx_clk_out;
	assign tx_clock_pin_in = cnt_q[4];
	// frame level chosen by the bench, which keeps the start delay sane
	assign rx_frame_pin_in = frame_lvl;
endmodule : ssrx_peer

// File: tb/ssrx_top_tb.sv
// self-checking bench for the receive clocking block
module ssrx_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
	logic        pready, pslverr, rc_in, rc_out, rc_oe_n, tc_in, fr_in, idle;
	logic        tx_start_evt = 1'h0, frame_lvl = 1'h0, rx_frame_sync, rx_bit_strobe, rx_data_active, irq;
	logic [15:0] lf = 16'h0063;
	logic [3:0]  modes [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
	logic [7:0]  offs [12] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30, 8'h34, 8'h40, 8'h4C, 8'h50, 8'h08};
	logic [15:0] cmds [7] = '{16'h0001, 16'h0000, 16'h0003, 16'h0100, 16'h0300, 16'h0101, 16'h8101};
	logic [1:0]  runs [7] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h0};
	int          fails = 0, total_checks = 0, cyc = 0, n, lat [2];
	logic [11:0] nlist [3] = '{12'h001, 12'h003, 12'hFFF};

	ssrx_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_clock_pin_in(rc_in), .rx_clock_pin_out(rc_out), .rx_clock_pin_oe_n(rc_oe_n),
		.tx_clock_pin_in(tc_in), .rx_frame_pin_in(fr_in), .tx_start_evt(tx_start_evt),
		.rx_frame_sync(rx_frame_sync), .rx_bit_strobe(rx_bit_strobe), .rx_data_active(rx_data_active),
		.irq(irq));
	ssrx_peer peer (.ref_clk(ref_clk), .rx_clk_oe_n(rc_oe_n), .rx_clk_out(rc_out), .frame_lvl(frame_lvl),
		.rx_clock_pin_in(rc_in), .tx_clock_pin_in(tc_in), .rx_frame_pin_in(fr_in));

	// 100 MHz clock
	initial forever #5 ref_clk = ~ref_clk;
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 70000) begin
			fails++;
			conclude();
		end
	end

	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	// rx clock config word from its fields
	function automatic logic [31:0] rcc(input logic [1:0] src, input logic [2:0] drv, input logic inv,
		input logic [3:0] st, input logic [7:0] dly, input logic [7:0] per);
		return {per, dly, 4'h0, st, 2'h0, inv, drv, src};
	endfunction : rcc
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask : apb
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0000_0000);
		cmp(what, exp, rd);
	endtask : rchk
	// cycles between two rising samples of the pin clock or the frame sync
	task automatic gap(input logic fs, output int g);
		logic p, s;
		int e, k;
		e = 0;
		k = 0;
		g = 0;
		p = 1'h1;
		while (e < 2 && k < 17000) begin
			@(posedge ref_clk);
			s = fs ? rx_frame_sync : rc_out;
			if (p === 1'h0 && s === 1'h1) e++;
			if (e > 0) g++;
			p = s;
			k++;
		end
		g = (e < 2) ? k : g - 1;
	endtask : gap
	// trigger a start in phase with the divided clock, then time the wait until the data phase begins
	task automatic start_lat(input logic [3:0] m, output int l);
		gap(1'h0, l);
		if (m == 4'h1) tx_start_evt <= 1'h1;
		else frame_lvl <= ~idle;
		@(posedge ref_clk);
		tx_start_evt <= 1'h0;
		l = 0;
		while (rx_data_active !== 1'h1 && l < 500) begin
			@(posedge ref_clk);
			l++;
		end
	endtask : start_lat
	task automatic strobes(output int c);
		c = 0;
		repeat (320) begin
			@(posedge ref_clk);
			if (rx_bit_strobe === 1'h1) c++;
		end
	endtask : strobes
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		foreach (offs[i]) rchk("reset value", offs[i], i == 8 ? ssrx_pkg::RST_EVENTS : ssrx_pkg::RST_ZERO);
		// random read back, read-only and unmapped places
		repeat (4) begin
			lf = nxt(lf);
			v = {lf, nxt(lf)};
			apb(1'h1, ssrx_pkg::OFF_TX_SYNC, v);
			rchk("tx sync word", ssrx_pkg::OFF_TX_SYNC, v);
			apb(1'h1, ssrx_pkg::OFF_RATE_SCALER, v & 32'h0000_0FFF);
			rchk("scaler", ssrx_pkg::OFF_RATE_SCALER, v & 32'h0000_0FFF);
		end
		apb(1'h1, ssrx_pkg::OFF_RX_WORD, v);
		rchk("rx word", ssrx_pkg::OFF_RX_WORD, 32'h0000_0000);
		apb(1'h1, 8'h08, v);
		rchk("unmapped", 8'h08, 32'h0000_0000);
		apb(1'h1, ssrx_pkg::OFF_IRQ_SET, 32'h0000_0004);
		cmp("irq on", 32'h0000_0001, 32'(irq));
		rchk("mask", ssrx_pkg::OFF_IRQ_STATE, 32'h0000_0004);
		apb(1'h1, ssrx_pkg::OFF_IRQ_CLEAR, 32'h0000_0004);
		cmp("irq off", 32'h0000_0000, 32'(irq));
		$display("test done: registers");
		foreach (cmds[i]) begin
			apb(1'h1, ssrx_pkg::OFF_COMMAND, {16'h0000, cmds[i]});
			rchk("run state", ssrx_pkg::OFF_RUN_STATE, 32'(runs[i]));
		end
		rchk("scaler after soft reset", ssrx_pkg::OFF_RATE_SCALER, 32'h0000_0000);
		$display("test done: commands");
		// clocks and frame sync with the receiver off
		apb(1'h1, ssrx_pkg::OFF_RX_CLOCK, rcc(2'h0, 3'h0, 1'h0, 4'h0, 8'h00, 8'h00));
		cmp("pin released", 32'h0000_0001, 32'(rc_oe_n));
		apb(1'h1, ssrx_pkg::OFF_RX_CLOCK, rcc(2'h0, 3'h1, 1'h0, 4'h0, 8'h00, 8'h00));
		gap(1'h0, n);
		cmp("scaler zero idle", 32'h0000_0001, 32'(n > 300));
		foreach (nlist[i]) begin
			apb(1'h1, ssrx_pkg::OFF_RATE_SCALER, 32'(nlist[i]));
			apb(1'h1, ssrx_pkg::OFF_RX_CLOCK, rcc(2'h0, 3'h1, i == 1, 4'h0, 8'h00, 8'h02));
			cmp("pin driven", 32'h0000_0000, 32'(rc_oe_n));
			gap(1'h0, n);
			cmp("divided period", 32'(2 * nlist[i]), 32'(n));
		end
		apb(1'h1, ssrx_pkg::OFF_RATE_SCALER, 32'h0000_0003);
		gap(1'h1, n);
		cmp("frame period", 32'(2 * 3 * 6), 32'(n));
		apb(1'h1, ssrx_pkg::OFF_RX_CLOCK, rcc(2'h0, 3'h1, 1'h0, 4'h0, 8'h00, 8'h00));
		gap(1'h1, n);
		cmp("no frame sync", 32'h0000_0001, 32'(n > 300));
		$display("test done: clocks");
		apb(1'h1, ssrx_pkg::OFF_RATE_SCALER, 32'h0000_0001);
		foreach (modes[i]) begin
			for (int d = 0; d < 2; d++) begin
				apb(1'h1, ssrx_pkg::OFF_COMMAND, 32'h0000_0002);
				idle = modes[i] == 4'h2 || modes[i] == 4'h4;
				frame_lvl <= idle;
				apb(1'h1, ssrx_pkg::OFF_RX_CLOCK, rcc(2'h0, 3'h1, 1'h0, modes[i], 8'(3 * d), 8'h00));
				repeat (10) @(posedge ref_clk);
				apb(1'h1, ssrx_pkg::OFF_COMMAND, 32'h0000_0001);
				repeat (20) @(posedge ref_clk);
				cmp("held before start", 32'h0000_0000, 32'(rx_data_active));
				start_lat(modes[i], lat[d]);
				cmp("start seen", 32'h0000_0001, 32'(lat[d] < 500));
			end
			cmp("start delay", 32'h0000_0006, 32'(lat[1] - lat[0]));
		end
		$display("test done: start modes");
		apb(1'h1, ssrx_pkg::OFF_COMMAND, 32'h0000_0002);
		apb(1'h1, ssrx_pkg::OFF_RX_CLOCK, rcc(2'h2, 3'h1, 1'h0, 4'h0, 8'h00, 8'h00));
		apb(1'h1, ssrx_pkg::OFF_COMMAND, 32'h0000_0001);
		repeat (40) @(posedge ref_clk);
		cmp("continuous start", 32'h0000_0001, 32'(rx_data_active));
		cmp("pin source released", 32'h0000_0001, 32'(rc_oe_n));
		strobes(n);
		cmp("rx pin strobes", 32'h0000_0001, 32'(n >= 19 && n <= 21));
		apb(1'h1, ssrx_pkg::OFF_RX_CLOCK, rcc(2'h1, 3'h0, 1'h0, 4'h0, 8'h00, 8'h00));
		strobes(n);
		cmp("tx pin strobes", 32'h0000_0001, 32'(n >= 9 && n <= 11));
		cmp("no bus error", 32'h0000_0000, 32'(pslverr));
		$display("test done: clock sources");
		conclude();
	end
endmodule : ssrx_top_tb
